// ---- zsr_zero_seq_reclose_ctrl.sv ----
// Purpose: zero sequence reclose controller with AXI4-Lite registers
// Assumes: enable, trip and blocked pins are asynchronous levels
// Notes:   all outputs are registered; irq is a level
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`include "zsr_cfg.svh"
`default_nettype none
module zsr_zero_seq_reclose_ctrl
  import zsr_pkg::*;
#(
  parameter int MS_CYCLES = `ZSR_MS_NS / `ZSR_CLK_NS
)(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        enableIn,
  input  wire logic        neutralOvTrip,
  input  wire logic        neutralOvBlocked,
  output var  logic        breakerCloseCmd,
  output var  logic        overvoltageHoldBlockOut,
  output var  logic        recloseActiveOut,
  output var  logic        recloseDisabledOut,
  output var  logic        irq,
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [5:0]  awaddr,
  input  wire logic        wvalid,
  output var  logic        wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output var  logic        bvalid,
  input  wire logic        bready,
  output var  logic [1:0]  bresp,
  input  wire logic        arvalid,
  output var  logic        arready,
  input  wire logic [5:0]  araddr,
  output var  logic        rvalid,
  input  wire logic        rready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp
);

  localparam logic [13:0] MS_LAST = 14'(MS_CYCLES - 1);

  zsr_regs_type r;
  zsr_regs_type next_r;
  logic         en;
  logic         trip;
  logic         blk;
  logic [4:0]   cur;
  logic [4:0]   nxt;
  logic [9:0]   ev;
  logic [9:0]   keep;
  logic [9:0]   clr;
  logic [31:0]  m;
  logic [31:0]  rd;
  logic         hWr;
  zsr_hist_type hRec;
  zsr_hist_type hOut;
  logic [3:0]   hFill;

  // ****************************************************
  // functions
  // ****************************************************
  function automatic logic mapped(input logic [5:0] a);
    return {a[5:2], 2'b00} <= `ZSR_OFF_HDATA;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction

  function automatic zsr_state_type forced(input logic [2:0] code);
    zsr_state_type s;
    unique case (code)
      `ZSR_FORCE_BLK:   s = ZSR_OFF;
      `ZSR_FORCE_REQ:   s = ZSR_ARMED;
      `ZSR_FORCE_CLOSE: s = ZSR_CLOSE;
      `ZSR_FORCE_HOLD:  s = ZSR_HOLD;
      default:          s = ZSR_IDLE;
    endcase
    return s;
  endfunction

  function automatic logic [2:0] condOf(input zsr_state_type s);
    logic [2:0] c;
    unique case (s)
      ZSR_IDLE:   c = `ZSR_COND_NORMAL;
      ZSR_ARMED:  c = `ZSR_COND_REQ;
      ZSR_TIMING: c = `ZSR_COND_ACT;
      ZSR_CLOSE:  c = `ZSR_COND_CLOSE;
      ZSR_HOLD:   c = `ZSR_COND_HOLD;
      ZSR_OFF:    c = `ZSR_COND_BLK;
      default:    c = `ZSR_COND_NORMAL;
    endcase
    return c;
  endfunction

  function automatic logic [3:0] firstSet(input logic [9:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 9; i >= 0; i--)
    begin
      if (v[i])
      begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  // ****************************************************
  // record history
  // ****************************************************
  zsr_history u_history (
    .clk    (clk),
    .arst_n (arst_n),
    .wrEn   (hWr),
    .wrRec  (hRec),
    .rdIdx  (r.histIdx),
    .rdRec  (hOut),
    .fill   (hFill)
  );

  // ****************************************************
  // next state
  // ****************************************************
  always_comb
  begin
    next_r = r;
    m = 32'h0;
    clr = 10'h0;
    rd = 32'h0;
    // pins are synchronised before use
    next_r.s1 = {neutralOvBlocked, neutralOvTrip, enableIn};
    next_r.s2 = r.s1;
    en = r.s2[0];
    trip = r.s2[1];
    blk = r.s2[2];

    // 1 ms stamp counter and 5 ms delay tick
    next_r.tick = 1'b0;
    if (r.msDiv == MS_LAST)
    begin
      next_r.msDiv = 14'h0;
      next_r.msCnt = r.msCnt + 32'h1;
      if (r.sub == `ZSR_TICK_MS - 3'h1)
      begin
        next_r.sub = 3'h0;
        next_r.tick = 1'b1;
      end
      else
      begin
        next_r.sub = r.sub + 3'h1;
      end
    end
    else
    begin
      next_r.msDiv = r.msDiv + 14'h1;
    end

    // reclose sequence
    unique case (r.st)
      ZSR_IDLE:
      begin
        if (trip)
        begin
          next_r.st = ZSR_ARMED;
        end
      end
      ZSR_ARMED:
      begin
        if (blk)
        begin
          next_r.st = ZSR_TIMING;
          next_r.dly = 19'h0;
        end
        else if (!trip)
        begin
          next_r.st = ZSR_IDLE;
        end
      end
      ZSR_TIMING:
      begin
        if (!blk)
        begin
          next_r.st = ZSR_IDLE;
          next_r.dly = 19'h0;
        end
        else if (r.dly > r.delay)
        begin
          // a full setting of whole ticks has passed
          next_r.st = ZSR_CLOSE;
          next_r.closeCnt = 3'h0;
        end
        else if (r.tick)
        begin
          next_r.dly = r.dly + 19'h1;
        end
      end
      ZSR_CLOSE:
      begin
        if (r.tick)
        begin
          next_r.closeCnt = r.closeCnt + 3'h1;
          if (r.closeCnt == `ZSR_CLOSE_TICKS - 3'h1)
          begin
            next_r.st = ZSR_HOLD;
          end
        end
      end
      ZSR_HOLD:
      begin
        if (!blk)
        begin
          next_r.st = ZSR_IDLE;
        end
      end
      ZSR_OFF:
      begin
        next_r.st = ZSR_IDLE;
      end
      default:
      begin
        next_r.st = ZSR_IDLE;
      end
    endcase
    if (!en)
    begin
      next_r.st = ZSR_OFF;
    end
    if (r.forceEn)
    begin
      next_r.st = forced(r.forceCode);
    end

    // outputs follow the next state
    next_r.disabledOut = (next_r.st == ZSR_OFF) || !en;
    next_r.activeOut = (next_r.st == ZSR_ARMED) ||
                       (next_r.st == ZSR_TIMING) ||
                       (next_r.st == ZSR_CLOSE) ||
                       (next_r.st == ZSR_HOLD);
    next_r.closeOut = (next_r.st == ZSR_CLOSE) && en;
    next_r.holdOut = (next_r.st == ZSR_TIMING) ||
                     (next_r.st == ZSR_CLOSE) ||
                     (next_r.st == ZSR_HOLD);
    next_r.cond = condOf(next_r.st);
    next_r.been = (next_r.st == ZSR_IDLE) ? 1'b0 :
                  (r.been | next_r.activeOut);

    // on/off events: even bit on, odd bit off
    cur = {r.holdOut, r.closeOut, r.activeOut, r.disabledOut,
           r.st == ZSR_ARMED};
    nxt = {next_r.holdOut, next_r.closeOut, next_r.activeOut,
           next_r.disabledOut, next_r.st == ZSR_ARMED};
    for (int k = 0; k < 5; k++)
    begin
      ev[2*k] = nxt[k] & ~cur[k];
      ev[2*k+1] = cur[k] & ~nxt[k];
    end
    keep = ev & r.evSel;
    if (|keep)
    begin
      next_r.evCode = firstSet(keep);
      next_r.evStamp = r.msCnt;
    end

    // close and blocked on events go to the history
    hWr = ev[`ZSR_EV_CLS_ON] | ev[`ZSR_EV_BLK_ON];
    hRec.stamp = r.msCnt;
    hRec.code = ev[`ZSR_EV_CLS_ON] ? `ZSR_EV_CLS_ON : `ZSR_EV_BLK_ON;
    hRec.group = r.group;
    hRec.left = (r.delay > r.dly) ? r.delay - r.dly : 19'h0;
    hRec.been = r.been;

    // register writes once address and data are both held
    if (awvalid && r.awready)
    begin
      next_r.awHeld = 1'b1;
      next_r.awAddr = awaddr;
    end
    if (wvalid && r.wready)
    begin
      next_r.wHeld = 1'b1;
      next_r.wData = wdata;
      next_r.wStrb = wstrb;
    end
    if (r.bvalid && bready)
    begin
      next_r.bvalid = 1'b0;
    end
    if (r.awHeld && r.wHeld && !r.bvalid)
    begin
      next_r.awHeld = 1'b0;
      next_r.wHeld = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = mapped(r.awAddr) ? `ZSR_RESP_OKAY : `ZSR_RESP_SLVERR;
      unique case ({r.awAddr[5:2], 2'b00})
        `ZSR_OFF_CTRL:
        begin
          m = merge({28'h0, r.forceCode, r.forceEn}, r.wData, r.wStrb);
          next_r.forceEn = m[`ZSR_CTRL_FORCE];
          next_r.forceCode = m[3:1];
        end
        `ZSR_OFF_DELAY:
        begin
          m = merge({13'h0, r.delay}, r.wData, r.wStrb);
          next_r.delay = m[18:0];
        end
        `ZSR_OFF_EVSEL:
        begin
          m = merge({22'h0, r.evSel}, r.wData, r.wStrb);
          next_r.evSel = m[9:0];
        end
        `ZSR_OFF_GROUP:
        begin
          m = merge({29'h0, r.group}, r.wData, r.wStrb);
          next_r.group = m[2:0];
        end
        `ZSR_OFF_ISTAT:
        begin
          m = merge(32'h0, r.wData, r.wStrb);
          clr = m[9:0];
        end
        `ZSR_OFF_IMASK:
        begin
          m = merge({22'h0, r.mask}, r.wData, r.wStrb);
          next_r.mask = m[9:0];
        end
        `ZSR_OFF_HIDX:
        begin
          m = merge({28'h0, r.histIdx}, r.wData, r.wStrb);
          next_r.histIdx = m[3:0];
        end
        default:
        begin
          m = 32'h0;
        end
      endcase
    end
    // a new event wins over a clear in the same cycle
    next_r.stat = (r.stat & ~clr) | keep;
    next_r.irq = |(next_r.stat & next_r.mask);
    next_r.awready = !next_r.awHeld && !next_r.bvalid;
    next_r.wready = !next_r.wHeld && !next_r.bvalid;

    // register reads
    unique case ({araddr[5:2], 2'b00})
      `ZSR_OFF_CTRL:    rd = {28'h0, r.forceCode, r.forceEn};
      `ZSR_OFF_DELAY:   rd = {13'h0, r.delay};
      `ZSR_OFF_EVSEL:   rd = {22'h0, r.evSel};
      `ZSR_OFF_GROUP:   rd = {29'h0, r.group};
      `ZSR_OFF_STATUS:  rd = {24'h0, en, r.holdOut, r.closeOut,
                              r.activeOut, r.disabledOut, r.cond};
      `ZSR_OFF_ISTAT:   rd = {22'h0, r.stat};
      `ZSR_OFF_IMASK:   rd = {22'h0, r.mask};
      `ZSR_OFF_TIME:    rd = r.msCnt;
      `ZSR_OFF_EVCODE:  rd = {28'h0, r.evCode};
      `ZSR_OFF_EVSTAMP: rd = r.evStamp;
      `ZSR_OFF_HIDX:    rd = {28'h0, r.histIdx};
      `ZSR_OFF_HCNT:    rd = {28'h0, hFill};
      `ZSR_OFF_HSTAMP:  rd = hOut.stamp;
      `ZSR_OFF_HDATA:   rd = {5'h0, hOut.been, hOut.left, hOut.group,
                              hOut.code};
      default:          rd = 32'h0;
    endcase
    if (r.rvalid && rready)
    begin
      next_r.rvalid = 1'b0;
    end
    if (arvalid && r.arready)
    begin
      next_r.rvalid = 1'b1;
      next_r.rdata = rd;
      next_r.rresp = mapped(araddr) ? `ZSR_RESP_OKAY : `ZSR_RESP_SLVERR;
    end
    next_r.arready = !next_r.rvalid;
  end

  // ****************************************************
  // state register
  // ****************************************************
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      r <= '0;
      // enable idles high, so reset alone logs no blocked event
      r.s1 <= 3'h1;
      r.s2 <= 3'h1;
      r.evSel <= `ZSR_EVSEL_RST;
      r.delay <= `ZSR_DLY_RST;
    end
    else
    begin
      r <= next_r;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  assign breakerCloseCmd = r.closeOut;
  assign overvoltageHoldBlockOut = r.holdOut;
  assign recloseActiveOut = r.activeOut;
  assign recloseDisabledOut = r.disabledOut;
  assign irq = r.irq;
  assign awready = r.awready;
  assign wready = r.wready;
  assign bvalid = r.bvalid;
  assign bresp = r.bresp;
  assign arready = r.arready;
  assign rvalid = r.rvalid;
  assign rdata = r.rdata;
  assign rresp = r.rresp;

endmodule
`default_nettype wire

// ---- zsr_cfg.svh ----
// Purpose: constants of the zero sequence reclose controller
// Assumes: 10 MHz clk, 32-bit AXI4-Lite register slave
// Notes:   offsets are byte addresses, fields sit in the low bits
// Overview of operation
// - enable low: disabled output, never close
// - trip seen: active output until fault clears
// - close only after trip and full delay
// - hold overvoltage block until fault clears
// - foreign fault: close, then both stay blocked
// - voltage drops after trip: no reclose
// - condition code values zero through five
// - on and off events, storage selectable
// - events stamped with 1 ms resolution
// - twelve record history of close, blocked
// - trip input starts the reclose sequence
// - 5 ms delay steps, blocked held throughout
// - forcing option sets status codes zero, one, two, four and five
`ifndef ZSR_CFG_SVH
`define ZSR_CFG_SVH

// ****************************************************
// timing
// ****************************************************
`define ZSR_CLK_NS      100
`define ZSR_MS_NS       1000000
`define ZSR_TICK_MS     3'h5
`define ZSR_CLOSE_TICKS 3'h4
`define ZSR_DLY_RST     19'h000c8
`define ZSR_HIST_N      12

// ****************************************************
// register offsets
// ****************************************************
`define ZSR_OFF_CTRL    6'h00
`define ZSR_OFF_DELAY   6'h04
`define ZSR_OFF_EVSEL   6'h08
`define ZSR_OFF_GROUP   6'h0c
`define ZSR_OFF_STATUS  6'h10
`define ZSR_OFF_ISTAT   6'h14
`define ZSR_OFF_IMASK   6'h18
`define ZSR_OFF_TIME    6'h1c
`define ZSR_OFF_EVCODE  6'h20
`define ZSR_OFF_EVSTAMP 6'h24
`define ZSR_OFF_HIDX    6'h28
`define ZSR_OFF_HCNT    6'h2c
`define ZSR_OFF_HSTAMP  6'h30
`define ZSR_OFF_HDATA   6'h34

// ****************************************************
// fields, reset values, codes
// ****************************************************
`define ZSR_CTRL_FORCE  0
`define ZSR_EVSEL_RST   10'h3ff
`define ZSR_EV_BLK_ON   4'h2
`define ZSR_EV_CLS_ON   4'h6
`define ZSR_COND_NORMAL 3'h0
`define ZSR_COND_REQ    3'h1
`define ZSR_COND_BLK    3'h2
`define ZSR_COND_ACT    3'h3
`define ZSR_COND_CLOSE  3'h4
`define ZSR_COND_HOLD   3'h5
`define ZSR_FORCE_BLK   3'h1
`define ZSR_FORCE_REQ   3'h2
`define ZSR_FORCE_CLOSE 3'h3
`define ZSR_FORCE_HOLD  3'h4
`define ZSR_RESP_OKAY   2'h0
`define ZSR_RESP_SLVERR 2'h2

`endif

// ---- zsr_pkg.sv ----
// Purpose: types of the zero sequence reclose controller
// Assumes: constants live in zsr_cfg.svh
// Notes:   state codes follow the usual path in gray order
`default_nettype none
package zsr_pkg;

  typedef enum logic [2:0]
  {
    ZSR_IDLE   = 3'h0,
    ZSR_ARMED  = 3'h1,
    ZSR_TIMING = 3'h3,
    ZSR_CLOSE  = 3'h2,
    ZSR_HOLD   = 3'h6,
    ZSR_OFF    = 3'h4
  } zsr_state_type;

  typedef struct packed {
    logic [31:0] stamp;
    logic [3:0]  code;
    logic [2:0]  group;
    logic [18:0] left;
    logic        been;
  } zsr_hist_type;

  typedef struct packed {
    zsr_hist_type [11:0] mem;
    logic [3:0]          wp;
    logic [3:0]          fill;
  } zsr_histmem_type;

  typedef struct packed {
    logic [2:0]    s1;
    logic [2:0]    s2;
    zsr_state_type st;
    logic [13:0]   msDiv;
    logic [31:0]   msCnt;
    logic [2:0]    sub;
    logic          tick;
    logic [18:0]   dly;
    logic [2:0]    closeCnt;
    logic          been;
    logic          disabledOut;
    logic          activeOut;
    logic          closeOut;
    logic          holdOut;
    logic [2:0]    cond;
    logic          irq;
    logic          forceEn;
    logic [2:0]    forceCode;
    logic [18:0]   delay;
    logic [9:0]    evSel;
    logic [2:0]    group;
    logic [9:0]    mask;
    logic [9:0]    stat;
    logic [3:0]    evCode;
    logic [31:0]   evStamp;
    logic [3:0]    histIdx;
    logic          awready;
    logic          wready;
    logic          awHeld;
    logic          wHeld;
    logic [5:0]    awAddr;
    logic [31:0]   wData;
    logic [3:0]    wStrb;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [1:0]    rresp;
    logic [31:0]   rdata;
  } zsr_regs_type;

endpackage
`default_nettype wire

// ---- zsr_history.sv ----
// Purpose: twelve entry record history, newest first on read
// Assumes: one write per clock at most
// Notes:   read index at or beyond fill returns zero
`include "zsr_cfg.svh"
`default_nettype none
module zsr_history
  import zsr_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         wrEn,
  input  wire zsr_hist_type wrRec,
  input  wire logic [3:0]   rdIdx,
  output var  zsr_hist_type rdRec,
  output var  logic [3:0]   fill
);

  localparam logic [4:0] DEPTH = 5'(`ZSR_HIST_N);

  zsr_histmem_type r;
  zsr_histmem_type next_r;
  logic [4:0]      slot;

  always_comb
  begin
    next_r = r;
    slot = 5'h0;
    if (wrEn)
    begin
      next_r.mem[r.wp] = wrRec;
      next_r.wp = (r.wp == 4'(DEPTH - 5'h1)) ? 4'h0 : r.wp + 4'h1;
      if (r.fill != 4'(DEPTH))
      begin
        next_r.fill = r.fill + 4'h1;
      end
    end
    // oldest entry is overwritten once all twelve are used
    slot = {1'b0, r.wp} + DEPTH - 5'h1 - {1'b0, rdIdx};
    if (slot >= DEPTH)
    begin
      slot = slot - DEPTH;
    end
    rdRec = '0;
    if (rdIdx < r.fill)
    begin
      rdRec = r.mem[slot[3:0]];
    end
    fill = r.fill;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

endmodule
`default_nettype wire

// ---- zsr_ov_partner.sv ----
// Purpose: overvoltage function and breaker seen from the controller
// Assumes: fault here clears once the breaker opens
// Notes:   breaker is restored whenever the fault is gone
`default_nettype none
module zsr_ov_partner
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       faultPresent,
  input  wire logic       faultHere,
  input  wire logic [3:0] openDelay,
  input  wire logic       closeCmd,
  input  wire logic       holdBlock,
  output logic            ovTrip,
  output logic            ovBlocked
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       brkOpen;
  logic [3:0] cnt;
  logic       volt;
  logic       blkIn;
  assign volt = faultPresent && !(faultHere && brkOpen);
  assign blkIn = holdBlock || brkOpen;
  assign ovTrip = volt && !blkIn;
  assign ovBlocked = volt && blkIn;
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      brkOpen <= 1'b0;
      cnt <= 4'h0;
    end
    else if (closeCmd || !faultPresent)
    begin
      brkOpen <= 1'b0;
      cnt <= 4'h0;
    end
    else if (ovTrip)
    begin
      cnt <= cnt + 4'h1;
      brkOpen <= (cnt >= openDelay);
    end
endmodule
`default_nettype wire

// ---- zsr_ctrl_props.sv ----
// Purpose: port checks of the reclose controller
// Assumes: reclose delay of at least one tick
// Notes:   bound from the testbench top
`default_nettype none
module zsr_ctrl_props
#(
  parameter int MS_CYCLES = 10000
)(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic enableIn,
  input wire logic neutralOvTrip,
  input wire logic neutralOvBlocked,
  input wire logic breakerCloseCmd,
  input wire logic overvoltageHoldBlockOut,
  input wire logic recloseActiveOut,
  input wire logic recloseDisabledOut,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICK = 5 * MS_CYCLES;
  logic [31:0] holdCnt;
  logic [31:0] closeCnt;
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      holdCnt <= '0;
      closeCnt <= '0;
    end
    else
    begin
      holdCnt <= overvoltageHoldBlockOut ? holdCnt + 1 : '0;
      closeCnt <= breakerCloseCmd ? closeCnt + 1 : '0;
    end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence idleReady;
    enableIn && !recloseActiveOut && !recloseDisabledOut;
  endsequence
  sequence faultSeen;
    ((neutralOvTrip || neutralOvBlocked) && enableIn) [*3];
  endsequence
  disabled_no_close_a: assert property (
    recloseDisabledOut |-> !breakerCloseCmd) else $error("close while off");
  enable_low_off_a: assert property (
    (!enableIn) [*4] |=> recloseDisabledOut) else $error("not disabled");
  trip_active_a: assert property (
    idleReady ##0 $rose(neutralOvTrip) |-> ##[2:4] recloseActiveOut)
    else $error("trip not seen");
  active_kept_a: assert property (
    faultSeen ##0 recloseActiveOut |=> recloseActiveOut)
    else $error("active dropped");
  close_cause_a: assert property (
    $rose(breakerCloseCmd) |-> holdCnt >= TICK && recloseActiveOut)
    else $error("close too early");
  close_len_a: assert property (
    $fell(breakerCloseCmd) |-> closeCnt >= 3 * TICK
    && closeCnt <= 4 * TICK + 1) else $error("close length");
  hold_in_close_a: assert property (
    breakerCloseCmd |-> overvoltageHoldBlockOut) else $error("no hold");
  clear_release_a: assert property (
    (enableIn && !neutralOvBlocked && !neutralOvTrip && !breakerCloseCmd)
    [*4] |=> !overvoltageHoldBlockOut) else $error("hold stuck");
  write_resp_a: assert property (
    awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  read_resp_a: assert property (
    arvalid && arready |=> rvalid && !arready) else $error("read late");
endmodule
`default_nettype wire

// ---- zsr_zero_seq_reclose_ctrl_tb_top.sv ----
// Purpose: self-checking bench of the reclose controller
// Assumes: one millisecond shortened to four clocks
// Notes:   reads and write responses are checked from a queue
`include "zsr_cfg.svh"
`default_nettype none
module zsr_zero_seq_reclose_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MS = 4;
  localparam int TICK = 5 * MS;
  localparam logic [2:0] FEXP [5] = '{3'h0, 3'h2, 3'h1, 3'h4, 3'h5};
  logic clk, arst_n, enableIn, faultPresent, faultHere, irq;
  logic neutralOvTrip, neutralOvBlocked, breakerCloseCmd;
  logic overvoltageHoldBlockOut, recloseActiveOut, recloseDisabledOut;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, openDelay;
  logic [1:0] bresp, rresp;
  logic [33:0] expQ[$], mskQ[$], m;
  int fails, n_tests, dly, n, hi;

  zsr_zero_seq_reclose_ctrl #(.MS_CYCLES(MS)) u_dut (.*);
  zsr_ov_partner u_ov (.clk(clk), .arst_n(arst_n),
    .faultPresent(faultPresent), .faultHere(faultHere),
    .openDelay(openDelay), .closeCmd(breakerCloseCmd),
    .holdBlock(overvoltageHoldBlockOut), .ovTrip(neutralOvTrip),
    .ovBlocked(neutralOvBlocked));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("mismatches %0d checks %0d", fails, n_tests);
    if (fails == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    int k;
    @(posedge clk);
    expQ.push_back({r, 32'h0});
    mskQ.push_back({2'h3, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50 && !(bvalid && bready); k++)
    begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (k == 50) fails++;
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] e,
                    input logic [31:0] msk, input logic [1:0] r);
    int k;
    @(posedge clk);
    expQ.push_back({r, e & msk});
    mskQ.push_back({2'h3, msk});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50 && !(rvalid && rready); k++)
    begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (k == 50) fails++;
  endtask

  // ****************************************
  // response monitor
  // ****************************************
  always @(posedge clk)
    if ((bvalid && bready) || (rvalid && rready))
    begin
      m = mskQ.pop_front();
      check((bvalid ? {bresp, 32'h0} : {rresp, rdata}) & m, expQ.pop_front());
    end

  initial
  begin
    #(100 * 30000);
    fails++;
    close_out();
  end

  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, openDelay} = '0;
    wstrb = 4'hf;
    {enableIn, faultPresent, faultHere, arst_n} = 4'h8;
    void'($urandom(23557));
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(`ZSR_OFF_DELAY, 32'hc8, '1, 2'h0);
    rd(`ZSR_OFF_EVSEL, 32'h3ff, '1, 2'h0);
    rd(`ZSR_OFF_HCNT, 32'h0, '1, 2'h0);
    rd(6'h38, 32'h0, '1, 2'h2);
    wr(6'h38, 32'h1, 2'h2);
    dly = 1 + $urandom % 3;
    openDelay <= 4'($urandom % 8);
    wr(`ZSR_OFF_DELAY, dly, 2'h0);
    rd(`ZSR_OFF_DELAY, dly, '1, 2'h0);
    wr(`ZSR_OFF_IMASK, 32'h40, 2'h0);
    enableIn <= 1'b0;
    for (int i = 1; i < 5; i++)
    begin
      wr(`ZSR_OFF_CTRL, (i << 1) | 1, 2'h0);
      rd(`ZSR_OFF_STATUS, FEXP[i], 32'h7, 2'h0);
    end
    wr(`ZSR_OFF_CTRL, 32'h0, 2'h0);
    // disabled: fault elsewhere never recloses
    faultPresent <= 1'b1;
    repeat ((dly + 3) * TICK) @(posedge clk);
    rd(`ZSR_OFF_STATUS, 32'h2, 32'h7, 2'h0);
    check(recloseDisabledOut, 1);
    faultPresent <= 1'b0;
    enableIn <= 1'b1;
    repeat (8) @(posedge clk);
    // fault on this feeder: voltage drops, no reclose
    {faultPresent, faultHere} <= 2'h3;
    for (n = 0; n < 20 && !recloseActiveOut; n++) @(posedge clk);
    check(recloseActiveOut, 1);
    hi = 0;
    repeat ((dly + 3) * TICK)
    begin
      @(posedge clk);
      hi += breakerCloseCmd;
    end
    check(hi, 0);
    rd(`ZSR_OFF_STATUS, 32'h0, 32'h7, 2'h0);
    {faultPresent, faultHere} <= 2'h0;
    repeat (8) @(posedge clk);
    // fault elsewhere: delayed close, then held block
    faultPresent <= 1'b1;
    for (n = 0; n < 100 && !overvoltageHoldBlockOut; n++) @(posedge clk);
    for (n = 0; n < 2000 && !breakerCloseCmd; n++) @(posedge clk);
    check(n >= dly * TICK && n <= (dly + 1) * TICK + 1,
          1);
    rd(`ZSR_OFF_STATUS, 32'h4, 32'h7, 2'h0);
    for (n = 0; n < 200 && breakerCloseCmd; n++) @(posedge clk);
    rd(`ZSR_OFF_STATUS, 32'h5, 32'h7, 2'h0);
    check(overvoltageHoldBlockOut, 1);
    rd(`ZSR_OFF_ISTAT, 32'h40, 32'h40, 2'h0);
    check(irq, 1);
    wr(`ZSR_OFF_IMASK, 32'h0, 2'h0);
    repeat (2) @(posedge clk);
    check(irq, 0);
    wr(`ZSR_OFF_ISTAT, 32'h40, 2'h0);
    rd(`ZSR_OFF_ISTAT, 32'h0, 32'h40, 2'h0);
    rd(`ZSR_OFF_HDATA, 32'h6, 32'hf, 2'h0);
    wr(`ZSR_OFF_HIDX, 32'h1, 2'h0);
    rd(`ZSR_OFF_HDATA, 32'h2, 32'hf, 2'h0);
    rd(`ZSR_OFF_HCNT, 32'h2, '1, 2'h0);
    faultPresent <= 1'b0;
    repeat (8) @(posedge clk);
    check({overvoltageHoldBlockOut, recloseActiveOut}, 0);
    rd(`ZSR_OFF_STATUS, 32'h0, 32'h7, 2'h0);
    // fault elsewhere gone before the delay runs out: no close
    faultPresent <= 1'b1;
    for (n = 0; n < 100 && !overvoltageHoldBlockOut; n++) @(posedge clk);
    faultPresent <= 1'b0;
    hi = 0;
    repeat ((dly + 3) * TICK)
    begin
      @(posedge clk);
      hi += breakerCloseCmd;
    end
    check(hi + overvoltageHoldBlockOut, 0);
    close_out();
  end
endmodule

bind zsr_zero_seq_reclose_ctrl zsr_ctrl_props #(.MS_CYCLES(MS_CYCLES))
  u_props (.*);
`default_nettype wire
